/* File: design/palette_host_port.sv */
`timescale 1ns/1ns
// host register port and colour lookup for a triple 8-bit palette
module palette_host_port #(
    parameter int PAL_DEPTH = 256,
    parameter int OVL_DEPTH = 16
) (
    // clock and reset
    input  wire logic       sys_clk,
    input  wire logic       sys_rst,
    // host bus pins, asynchronous
    input  wire logic       rd_n,
    input  wire logic       wr_n,
    input  wire logic [2:0] register_select,
    input  wire logic [7:0] host_data_in,
    output logic      [7:0] host_data_out,
    output logic            host_data_oe,
    // pixel inputs, on sys_clk
    input  wire logic [7:0] pix_red,
    input  wire logic [7:0] pix_green,
    input  wire logic [7:0] pix_blue,
    input  wire logic [3:0] overlay_select,
    input  wire logic       format_sel_low,
    input  wire logic       format_sel_high,
    // converter inputs and command pins
    output logic      [7:0] dac_red,
    output logic      [7:0] dac_green,
    output logic      [7:0] dac_blue,
    output logic      [3:0] cmd_pins,
    output logic            setup_select
);

    logic [23:0]  pal_ff [PAL_DEPTH];
    logic [23:0]  ovl_ff [OVL_DEPTH];
    logic [7:0]   palette_index_ff;
    logic [1:0]   byte_phase_counter_ff;
    palette_pkg::access_mode_e mode_ff;
    logic [7:0]   hold_r_ff;
    logic [7:0]   hold_g_ff;
    logic [7:0]   hold_b_ff;
    logic [7:0]   mask_ff;
    logic [7:0]   cmd_ff;
    logic [12:0]  pins_s;
    logic         rd_n_s;
    logic         wr_n_s;
    logic         rd_prev_ff;
    logic         wr_prev_ff;
    logic [2:0]   rs_ff;
    logic [7:0]   wdata_ff;
    logic         wr_end;
    logic         rd_end;
    logic         idx_wr;
    logic         data_acc;
    logic         blue_acc;
    logic [7:0]   fetch_addr;
    logic [23:0]  fetch_word;
    logic [7:0]   nxt_rdata;
    logic [29:0]  pix_d;
    logic [23:0]  nxt_color;
    logic [23:0]  color_ff;
    logic         six_ff;

    // resynchronise strobes, select and data
    pin_sync #(.WIDTH(13)) u_sync (
        .sys_clk   (sys_clk),
        .sys_rst   (sys_rst),
        .async_in  ({rd_n, wr_n, register_select, host_data_in}),
        .reset_val (13'h1FFF),
        .sync_out  (pins_s)
    );
    assign rd_n_s = pins_s[12];
    assign wr_n_s = pins_s[11];

    function automatic logic [7:0] conv_in(input logic [7:0] d, input logic wide);
        conv_in = wide ? d : {d[5:0], 2'h0};
    endfunction
    function automatic logic [7:0] conv_out(input logic [7:0] v, input logic wide);
        conv_out = wide ? v : {2'h0, v[7:2]};
    endfunction
    function automatic logic is_index(input logic [2:0] rs);
        is_index = (rs == palette_pkg::RS_INDEX_PW) || (rs == palette_pkg::RS_INDEX_PR)
                || (rs == palette_pkg::RS_INDEX_OW) || (rs == palette_pkg::RS_INDEX_OR);
    endfunction

    // strobe edge history and latched select and data
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            rd_prev_ff <= 1'b1;
            wr_prev_ff <= 1'b1;
            rs_ff      <= 3'h0;
            wdata_ff   <= 8'h00;
        end else begin
            rd_prev_ff <= rd_n_s;
            wr_prev_ff <= wr_n_s;
            if (!rd_n_s || !wr_n_s) begin
                rs_ff <= pins_s[10:8];
            end
            if (!wr_n_s) begin
                wdata_ff <= pins_s[7:0];
            end
        end
    end

    // access ends on synced strobe release
    assign wr_end   = wr_n_s && !wr_prev_ff;
    assign rd_end   = rd_n_s && !rd_prev_ff;
    assign idx_wr   = wr_end && is_index(rs_ff);
    assign data_acc = (wr_end || rd_end) && (rs_ff == palette_pkg::RS_PALETTE || rs_ff == palette_pkg::RS_OVERLAY);
    assign blue_acc = data_acc && (byte_phase_counter_ff == palette_pkg::PHASE_BLUE);

    // overlay entry fetch uses low nibble only
    always_comb begin
        fetch_addr = idx_wr ? wdata_ff : palette_index_ff;
        if (rs_ff[2]) begin
            fetch_word = (fetch_addr[3:0] == palette_pkg::OVL_RESERVED) ? 24'h000000 : ovl_ff[fetch_addr[3:0]];
        end else begin
            fetch_word = pal_ff[fetch_addr];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            palette_index_ff      <= palette_pkg::INDEX_RESET;
            byte_phase_counter_ff <= palette_pkg::PHASE_RED;
            mode_ff               <= palette_pkg::MODE_PAL_WRITE;
        end else if (idx_wr) begin
            byte_phase_counter_ff <= palette_pkg::PHASE_RED;
            case (rs_ff)
                palette_pkg::RS_INDEX_PR: begin
                    mode_ff          <= palette_pkg::MODE_PAL_READ;
                    palette_index_ff <= wdata_ff + 8'h01;
                end
                palette_pkg::RS_INDEX_OR: begin
                    mode_ff          <= palette_pkg::MODE_OVL_READ;
                    palette_index_ff <= wdata_ff + 8'h01;
                end
                palette_pkg::RS_INDEX_OW: begin
                    mode_ff          <= palette_pkg::MODE_OVL_WRITE;
                    palette_index_ff <= wdata_ff;
                end
                default: begin
                    mode_ff          <= palette_pkg::MODE_PAL_WRITE;
                    palette_index_ff <= wdata_ff;
                end
            endcase
        end else if (blue_acc) begin
            // phase back to red after blue
            byte_phase_counter_ff <= palette_pkg::PHASE_RED;
            palette_index_ff      <= palette_index_ff + 8'h01;
        end else if (data_acc) begin
            byte_phase_counter_ff <= byte_phase_counter_ff + 2'h1;
        end
    end

    // holding registers stage bytes and fetched entries
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            hold_r_ff <= 8'h00;
            hold_g_ff <= 8'h00;
            hold_b_ff <= 8'h00;
        end else if ((idx_wr && rs_ff[1:0] == 2'h3) || (rd_end && blue_acc)) begin
            {hold_r_ff, hold_g_ff, hold_b_ff} <= fetch_word;
        end else if (wr_end && data_acc) begin
            case (byte_phase_counter_ff)
                palette_pkg::PHASE_RED:   hold_r_ff <= conv_in(wdata_ff, cmd_ff[palette_pkg::WIDTH_SELECT]);
                palette_pkg::PHASE_GREEN: hold_g_ff <= conv_in(wdata_ff, cmd_ff[palette_pkg::WIDTH_SELECT]);
                default:                  hold_b_ff <= conv_in(wdata_ff, cmd_ff[palette_pkg::WIDTH_SELECT]);
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (wr_end && blue_acc && rs_ff == palette_pkg::RS_PALETTE) begin
            pal_ff[palette_index_ff] <= {hold_r_ff, hold_g_ff, conv_in(wdata_ff, cmd_ff[palette_pkg::WIDTH_SELECT])};
        end
    end

    always_ff @(posedge sys_clk) begin
        if (wr_end && blue_acc && rs_ff == palette_pkg::RS_OVERLAY
                && palette_index_ff[3:0] != palette_pkg::OVL_RESERVED) begin
            ovl_ff[palette_index_ff[3:0]] <= {hold_r_ff, hold_g_ff, conv_in(wdata_ff, cmd_ff[palette_pkg::WIDTH_SELECT])};
        end
    end

    // mask and command registers
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            mask_ff <= palette_pkg::MASK_RESET;
            cmd_ff  <= palette_pkg::COMMAND_RESET;
        end else if (wr_end && rs_ff == palette_pkg::RS_MASK) begin
            mask_ff <= wdata_ff;
        end else if (wr_end && rs_ff == palette_pkg::RS_COMMAND) begin
            cmd_ff  <= wdata_ff;
        end
    end

    // read value select, index read has no side effect
    always_comb begin
        case (pins_s[10:8])
            palette_pkg::RS_MASK:    nxt_rdata = mask_ff;
            palette_pkg::RS_COMMAND: nxt_rdata = cmd_ff;
            palette_pkg::RS_PALETTE, palette_pkg::RS_OVERLAY: begin
                case (byte_phase_counter_ff)
                    palette_pkg::PHASE_RED:   nxt_rdata = conv_out(hold_r_ff, cmd_ff[palette_pkg::WIDTH_SELECT]);
                    palette_pkg::PHASE_GREEN: nxt_rdata = conv_out(hold_g_ff, cmd_ff[palette_pkg::WIDTH_SELECT]);
                    default:                  nxt_rdata = conv_out(hold_b_ff, cmd_ff[palette_pkg::WIDTH_SELECT]);
                endcase
            end
            default: nxt_rdata = palette_index_ff;
        endcase
    end

    // drive read data while read strobe is low
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            host_data_out <= 8'h00;
            host_data_oe  <= 1'b0;
        end else begin
            host_data_out <= rd_n_s ? 8'h00 : nxt_rdata;
            host_data_oe  <= !rd_n_s;
        end
    end

    // format inputs ride with pixel data
    pixel_delay #(.WIDTH(30), .DEPTH(palette_pkg::PIXEL_PRE_STAGES)) u_delay (
        .sys_clk (sys_clk),
        .sys_rst (sys_rst),
        .din     ({format_sel_high, format_sel_low, overlay_select, pix_red, pix_green, pix_blue}),
        .dout    (pix_d)
    );

    // colour mode from format and qualifiers
    always_comb begin
        logic [1:0] fmt;
        logic [1:0] qual;
        logic [7:0] pr;
        logic [7:0] pg;
        logic [7:0] pb;
        logic [7:0] p8;
        fmt  = pix_d[29:28];
        qual = cmd_ff[palette_pkg::QUALIFIER_HIGH:palette_pkg::QUALIFIER_LOW];
        pr   = pix_d[23:16];
        pg   = pix_d[15:8];
        pb   = pix_d[7:0];
        p8   = 8'h00;
        case (qual)
            palette_pkg::QUAL_RED:   p8 = pr;
            palette_pkg::QUAL_GREEN: p8 = pg;
            default:                 p8 = pb;
        endcase
        nxt_color = 24'h000000;
        case (fmt)
            palette_pkg::FMT_PAL24: begin
                if (qual != 2'h3) begin
                    nxt_color = {pal_ff[pr & mask_ff][23:16], pal_ff[pg & mask_ff][15:8], pal_ff[pb & mask_ff][7:0]};
                end
            end
            palette_pkg::FMT_DIR24: begin
                if (qual != 2'h3) begin
                    nxt_color = {pr, pg, pb};
                end
            end
            palette_pkg::FMT_PAL8: begin
                if (qual != 2'h3) begin
                    nxt_color = pal_ff[p8 & mask_ff];
                end
            end
            default: begin
                if (qual != 2'h3) begin
                    nxt_color = {p8[7:5], 5'h00, p8[4:2], 5'h00, p8[1:0], 6'h00};
                end else begin
                    nxt_color = {pr[6:2], 3'h0, pr[1:0], pg[7:5], 3'h0, pg[4:0], 3'h0};
                end
            end
        endcase
        if (pix_d[27:24] != palette_pkg::OVL_RESERVED) begin
            nxt_color = ovl_ff[pix_d[27:24]];
        end
    end

    // lookup stage and converter stage
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            color_ff <= 24'h000000;
            six_ff   <= 1'b0;
            dac_red   <= 8'h00;
            dac_green <= 8'h00;
            dac_blue  <= 8'h00;
        end else begin
            color_ff <= nxt_color;
            six_ff   <= !cmd_ff[palette_pkg::WIDTH_SELECT];
            dac_red   <= six_ff ? {color_ff[23:18], 2'h0} : color_ff[23:16];
            dac_green <= six_ff ? {color_ff[15:10], 2'h0} : color_ff[15:8];
            dac_blue  <= six_ff ? {color_ff[7:2], 2'h0} : color_ff[7:0];
        end
    end

    // command pin outputs
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            cmd_pins     <= 4'h0;
            setup_select <= 1'b0;
        end else begin
            cmd_pins     <= cmd_ff[3:0];
            setup_select <= cmd_ff[palette_pkg::SETUP_SELECT];
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    property p_idx_wr_clears;
        idx_wr |=> byte_phase_counter_ff == palette_pkg::PHASE_RED;
    endproperty
    a_idx_wr_clears: assert property (p_idx_wr_clears) else $error("phase not cleared");

    property p_idx_rd_keeps;
        (rd_end && is_index(rs_ff)) |=> $stable(palette_index_ff) && $stable(mode_ff);
    endproperty
    a_idx_rd_keeps: assert property (p_idx_rd_keeps) else $error("index read altered state");

    property p_blue_inc;
        (wr_end && blue_acc) |=> palette_index_ff == $past(palette_index_ff) + 8'h01;
    endproperty
    a_blue_inc: assert property (p_blue_inc) else $error("no increment after blue");

    property p_phase_range;
        byte_phase_counter_ff != 2'h3;
    endproperty
    a_phase_range: assert property (p_phase_range) else $error("phase out of range");

    property p_wrap;
        (blue_acc && palette_index_ff == 8'hFF) |=> palette_index_ff == 8'h00;
    endproperty
    a_wrap: assert property (p_wrap) else $error("index did not wrap");

    property p_six_lsb;
        six_ff |=> dac_red[1:0] == 2'h0 && dac_green[1:0] == 2'h0 && dac_blue[1:0] == 2'h0;
    endproperty
    a_six_lsb: assert property (p_six_lsb) else $error("6-bit lsbs not zero");

    property p_read_upper;
        (!rd_n_s && pins_s[10:8] == palette_pkg::RS_PALETTE && !cmd_ff[palette_pkg::WIDTH_SELECT])
            |=> host_data_out[7:6] == 2'h0 && host_data_oe;
    endproperty
    a_read_upper: assert property (p_read_upper) else $error("6-bit read upper bits set");

    property p_pr_load;
        (idx_wr && rs_ff == palette_pkg::RS_INDEX_PR)
            |=> palette_index_ff == $past(wdata_ff) + 8'h01 && mode_ff == palette_pkg::MODE_PAL_READ;
    endproperty
    a_pr_load: assert property (p_pr_load) else $error("read-mode load wrong");

    c_pal_write: cover property (wr_end && blue_acc && rs_ff == palette_pkg::RS_PALETTE);
    c_ovl_read: cover property (rd_end && blue_acc && rs_ff == palette_pkg::RS_OVERLAY);
    c_wrap: cover property (blue_acc && palette_index_ff == 8'hFF);

endmodule // palette_host_port

/* File: design/palette_pkg.sv */
package palette_pkg;

    // register select codes
    localparam logic [2:0] RS_INDEX_PW = 3'h0;
    localparam logic [2:0] RS_PALETTE  = 3'h1;
    localparam logic [2:0] RS_MASK     = 3'h2;
    localparam logic [2:0] RS_INDEX_PR = 3'h3;
    localparam logic [2:0] RS_INDEX_OW = 3'h4;
    localparam logic [2:0] RS_OVERLAY  = 3'h5;
    localparam logic [2:0] RS_COMMAND  = 3'h6;
    localparam logic [2:0] RS_INDEX_OR = 3'h7;

    // byte phase values
    localparam logic [1:0] PHASE_RED   = 2'h0;
    localparam logic [1:0] PHASE_GREEN = 2'h1;
    localparam logic [1:0] PHASE_BLUE  = 2'h2;

    // command register fields
    localparam int QUALIFIER_HIGH = 7;
    localparam int QUALIFIER_LOW  = 6;
    localparam int SETUP_SELECT   = 5;
    localparam int WIDTH_SELECT   = 4;

    // format codes and qualifier codes
    localparam logic [1:0] FMT_PAL24  = 2'h0;
    localparam logic [1:0] FMT_DIR24  = 2'h1;
    localparam logic [1:0] FMT_PAL8   = 2'h2;
    localparam logic [1:0] FMT_DIR8   = 2'h3;
    localparam logic [1:0] QUAL_RED   = 2'h0;
    localparam logic [1:0] QUAL_GREEN = 2'h1;
    localparam logic [1:0] QUAL_BLUE  = 2'h2;

    // reset values and reserved overlay entry
    localparam logic [7:0] INDEX_RESET   = 8'h00;
    localparam logic [7:0] COMMAND_RESET = 8'h00;
    localparam logic [7:0] MASK_RESET    = 8'hFF;
    localparam logic [3:0] OVL_RESERVED  = 4'h0;

    // pixel path depth before lookup stage
    localparam int PIXEL_PRE_STAGES = 2;

    typedef enum logic [1:0] {
        MODE_PAL_WRITE,
        MODE_PAL_READ,
        MODE_OVL_WRITE,
        MODE_OVL_READ
    } access_mode_e;

endpackage

/* File: design/pin_sync.sv */
`timescale 1ns/1ns
// two-stage synchroniser for pins from outside the clock domain
module pin_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             sys_clk,
    input  wire logic             sys_rst,
    // async in, synced out
    input  wire logic [WIDTH-1:0] async_in,
    input  wire logic [WIDTH-1:0] reset_val,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_ff;

    // first stage is read only by the second
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            meta_ff  <= reset_val;
            sync_out <= reset_val;
        end else begin
            meta_ff  <= async_in;
            sync_out <= meta_ff;
        end
    end

endmodule // pin_sync

/* File: design/pixel_delay.sv */
`timescale 1ns/1ns
// shift register that keeps format inputs aligned with pixel data
module pixel_delay #(
    parameter int WIDTH = 30,
    parameter int DEPTH = 2
) (
    // clock and reset
    input  wire logic             sys_clk,
    input  wire logic             sys_rst,
    // data in and delayed data out
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);

    logic [WIDTH-1:0] stage_ff [DEPTH];

    // all pixel and format bits share one chain
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            for (int i = 0; i < DEPTH; i++) begin
                stage_ff[i] <= '0;
            end
        end else begin
            stage_ff[0] <= din;
            for (int i = 1; i < DEPTH; i++) begin
                stage_ff[i] <= stage_ff[i-1];
            end
        end
    end

    assign dout = stage_ff[DEPTH-1];

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    property p_delay_aligned;
        !$past(sys_rst, 2) |-> dout == $past(din, 2);
    endproperty
    a_delay_aligned: assert property (p_delay_aligned) else $error("pixel chain misaligned");

endmodule // pixel_delay

/* File: bench/host_model.sv */
`timescale 1ns/1ns
// processor side of the register port
module host_model (
    // clock
    input  wire logic       sys_clk,
    // host bus pins
    output logic            rd_n,
    output logic            wr_n,
    output logic      [2:0] register_select,
    output logic      [7:0] host_data_in,
    input  wire logic [7:0] host_data_out,
    input  wire logic       host_data_oe
);
    // idle bus at time zero
    initial begin
        rd_n = 1'b1;
        wr_n = 1'b1;
        register_select = 3'h0;
        host_data_in = 8'h5A;
    end
    // write strobe, data held past release, then scrambled
    // index load precedes bytes, sparse accesses
    task automatic wr(input logic [2:0] sel, input logic [7:0] d);
        register_select = sel;
        host_data_in = d;
        wr_n = 1'b0;
        repeat (4) @(negedge sys_clk);
        wr_n = 1'b1;
        repeat (4) @(negedge sys_clk);
        host_data_in = ~d;
        repeat (2) @(negedge sys_clk);
    endtask
    // read strobe, answer taken before release
    task automatic rd(input logic [2:0] sel, output logic [7:0] q, output logic oe);
        register_select = sel;
        rd_n = 1'b0;
        repeat (4) @(negedge sys_clk);
        q = host_data_out;
        oe = host_data_oe;
        rd_n = 1'b1;
        repeat (6) @(negedge sys_clk);
    endtask
endmodule // host_model

/* File: bench/test_palette_host_port.sv */
`timescale 1ns/1ns
// bench for the palette host port
module test_palette_host_port;
    logic       sys_clk = 1'b0;
    logic       sys_rst = 1'b1;
    logic       rd_n;
    logic       wr_n;
    logic [2:0] register_select;
    logic [7:0] host_data_in;
    logic [7:0] host_data_out;
    logic       host_data_oe;
    logic [7:0] pix_red = 8'h00;
    logic [7:0] pix_green = 8'h00;
    logic [7:0] pix_blue = 8'h00;
    logic [3:0] overlay_select = 4'h0;
    logic       format_sel_low = 1'b0;
    logic       format_sel_high = 1'b0;
    logic [7:0] dac_red;
    logic [7:0] dac_green;
    logic [7:0] dac_blue;
    logic [3:0] cmd_pins;
    logic       setup_select;
    logic [7:0] q;
    logic       oe;
    int         failures = 0;
    int         check_count = 0;
    // clock
    always #10 sys_clk = ~sys_clk;
    palette_host_port palette_host_port_i (.sys_clk(sys_clk), .sys_rst(sys_rst), .rd_n(rd_n), .wr_n(wr_n),
        .register_select(register_select), .host_data_in(host_data_in), .host_data_out(host_data_out),
        .host_data_oe(host_data_oe), .pix_red(pix_red), .pix_green(pix_green), .pix_blue(pix_blue),
        .overlay_select(overlay_select), .format_sel_low(format_sel_low), .format_sel_high(format_sel_high),
        .dac_red(dac_red), .dac_green(dac_green), .dac_blue(dac_blue), .cmd_pins(cmd_pins),
        .setup_select(setup_select));
    host_model host_model_i (.sys_clk(sys_clk), .rd_n(rd_n), .wr_n(wr_n), .register_select(register_select),
        .host_data_in(host_data_in), .host_data_out(host_data_out), .host_data_oe(host_data_oe));
    // compare one byte
    task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
        check_count++;
        if (g !== e) begin
            $display("Error %s expected %h seen %h", n, e, g);
            failures++;
        end
    endtask
    // read and compare
    task automatic rchk(input logic [2:0] s, input logic [7:0] e);
        host_model_i.rd(s, q, oe);
        chk8("read data", e, q);
    endtask
    // three colour bytes
    task automatic wtrip(input logic [2:0] s, input logic [7:0] r, g, b);
        host_model_i.wr(s, r);
        host_model_i.wr(s, g);
        host_model_i.wr(s, b);
    endtask
    // drive one pixel for one cycle
    task automatic pix(input logic [1:0] f, input logic [7:0] v, input logic [3:0] ol);
        {format_sel_high, format_sel_low} = f;
        pix_red = v;
        pix_green = v + 8'h22;
        pix_blue = v + 8'h44;
        overlay_select = ol;
        @(negedge sys_clk);
    endtask
    // converter outputs
    task automatic dchk(input logic [7:0] r, g, b);
        chk8("dac red", r, dac_red);
        chk8("dac green", g, dac_green);
        chk8("dac blue", b, dac_blue);
    endtask
    // reset values and bus release
    task automatic t_reset;
        host_model_i.rd(palette_pkg::RS_INDEX_PW, q, oe);
        chk8("index", palette_pkg::INDEX_RESET, q);
        chk8("oe read", 8'h01, {7'h00, oe});
        chk8("oe idle", 8'h00, {7'h00, host_data_oe});
        rchk(palette_pkg::RS_COMMAND, palette_pkg::COMMAND_RESET);
        rchk(palette_pkg::RS_MASK, palette_pkg::MASK_RESET);
    endtask
    logic [7:0] q_exp [6] = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66};
    // palette fill across the top, read back with prefetch
    task automatic t_wrap;
        host_model_i.wr(palette_pkg::RS_COMMAND, 8'h3B);
        chk8("cmd pins", 8'h0B, {4'h0, cmd_pins});
        chk8("setup", 8'h01, {7'h00, setup_select});
        host_model_i.wr(palette_pkg::RS_INDEX_PW, 8'hFE);
        wtrip(palette_pkg::RS_PALETTE, 8'h11, 8'h22, 8'h33);
        wtrip(palette_pkg::RS_PALETTE, 8'h44, 8'h55, 8'h66);
        rchk(palette_pkg::RS_INDEX_PW, 8'h00);
        host_model_i.wr(palette_pkg::RS_INDEX_PR, 8'hFE);
        rchk(palette_pkg::RS_INDEX_PW, 8'hFF);
        foreach (q_exp[i]) rchk(palette_pkg::RS_PALETTE, q_exp[i]);
        rchk(palette_pkg::RS_INDEX_PW, 8'h01);
    endtask
    // partial triple, index rewrite clears the phase
    task automatic t_phase;
        host_model_i.wr(palette_pkg::RS_INDEX_PW, 8'h20);
        host_model_i.wr(palette_pkg::RS_PALETTE, 8'hAA);
        rchk(palette_pkg::RS_INDEX_PW, 8'h20);
        host_model_i.wr(palette_pkg::RS_INDEX_PW, 8'h20);
        host_model_i.wr(palette_pkg::RS_PALETTE, 8'h01);
        rchk(palette_pkg::RS_INDEX_PW, 8'h20);
        host_model_i.wr(palette_pkg::RS_PALETTE, 8'h02);
        host_model_i.wr(palette_pkg::RS_PALETTE, 8'h03);
        rchk(palette_pkg::RS_INDEX_PW, 8'h21);
        host_model_i.wr(palette_pkg::RS_INDEX_PR, 8'h20);
        rchk(palette_pkg::RS_PALETTE, 8'h01);
        rchk(palette_pkg::RS_PALETTE, 8'h02);
        rchk(palette_pkg::RS_PALETTE, 8'h03);
    endtask
    // overlay entries, upper nibble ignored, entry zero reserved
    task automatic t_overlay;
        host_model_i.wr(palette_pkg::RS_INDEX_OW, 8'hF3);
        wtrip(palette_pkg::RS_OVERLAY, 8'h12, 8'h34, 8'h56);
        rchk(palette_pkg::RS_INDEX_OW, 8'hF4);
        host_model_i.wr(palette_pkg::RS_INDEX_OR, 8'h23);
        rchk(palette_pkg::RS_OVERLAY, 8'h12);
        rchk(palette_pkg::RS_OVERLAY, 8'h34);
        rchk(palette_pkg::RS_OVERLAY, 8'h56);
        rchk(palette_pkg::RS_INDEX_OR, 8'h25);
        host_model_i.wr(palette_pkg::RS_INDEX_OW, 8'h00);
        wtrip(palette_pkg::RS_OVERLAY, 8'h77, 8'h77, 8'h77);
        host_model_i.wr(palette_pkg::RS_INDEX_OR, 8'h00);
        repeat (3) rchk(palette_pkg::RS_OVERLAY, 8'h00);
    endtask
    // six-bit transfers and converter lsbs
    task automatic t_width;
        host_model_i.wr(palette_pkg::RS_COMMAND, 8'h0B);
        host_model_i.wr(palette_pkg::RS_INDEX_PW, 8'h40);
        wtrip(palette_pkg::RS_PALETTE, 8'hFF, 8'hC1, 8'h80);
        host_model_i.wr(palette_pkg::RS_INDEX_PR, 8'h40);
        rchk(palette_pkg::RS_PALETTE, 8'h3F);
        rchk(palette_pkg::RS_PALETTE, 8'h01);
        rchk(palette_pkg::RS_PALETTE, 8'h00);
        {pix_red, pix_green, pix_blue} = {3{8'h40}};
        repeat (5) @(negedge sys_clk);
        dchk(8'hFC, 8'h04, 8'h00);
        host_model_i.wr(palette_pkg::RS_COMMAND, 8'h3B);
    endtask
    // format follows its own pixel, overlay wins
    task automatic t_pixel;
        pix(palette_pkg::FMT_PAL8, 8'hFE, 4'h0);
        pix(palette_pkg::FMT_DIR24, 8'h9A, 4'h0);
        pix(palette_pkg::FMT_DIR24, 8'h9A, 4'h3);
        @(negedge sys_clk);
        dchk(8'h11, 8'h22, 8'h33);
        @(negedge sys_clk);
        dchk(8'h9A, 8'hBC, 8'hDE);
        @(negedge sys_clk);
        dchk(8'h12, 8'h34, 8'h56);
        pix(palette_pkg::FMT_DIR8, 8'h9A, 4'h0);
        repeat (3) @(negedge sys_clk);
        dchk(8'h80, 8'hC0, 8'h80);
        host_model_i.wr(palette_pkg::RS_COMMAND, 8'hFB);
        repeat (4) @(negedge sys_clk);
        dchk(8'h30, 8'hA8, 8'hE0);
    endtask
    // verdict
    task automatic conclude;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // watchdog
    initial begin
        #200000;
        failures++;
        conclude();
    end
    // main sequence
    initial begin
        repeat (5) @(negedge sys_clk);
        sys_rst = 1'b0;
        @(negedge sys_clk);
        t_reset();
        t_wrap();
        t_phase();
        t_overlay();
        t_width();
        t_pixel();
        conclude();
    end
endmodule // test_palette_host_port
